// ---- hdl/chan_counter.sv ----
// Down counter with start load, zero reload and stop freeze
`timescale 1ns/1ps
`include "timer_cfg.svh"
module chan_counter #(
  parameter int W = 16
) (
  input  wire logic         clk,       // Clock
  input  wire logic         sys_rst,   // Async reset
  input  wire logic         ce,        // Clock enable
  input  wire logic         clr,       // Unit disabled
  input  wire logic         start,     // Start trigger pulse
  input  wire logic         stop,      // Stop trigger pulse
  input  wire logic         tick,      // Count clock
  input  wire logic         start_int, // Fire on first load
  input  wire logic [W-1:0] period,    // Reload value
  output logic      [W-1:0] count,     // Counter value
  output logic              running,   // Enable status
  output logic              fire       // Interval event, combinational
);
  logic         load_pend, next_load_pend, next_running;
  logic [W-1:0] next_count;

  // Start wins over stop; a pending load waits for the next count clock
  always_comb begin
    next_count     = count;
    next_running   = running;
    next_load_pend = load_pend;
    fire           = 1'b0;
    if (clr) begin
      next_count     = '0;
      next_running   = 1'b0;
      next_load_pend = 1'b0;
    end else if (start) begin
      next_running   = 1'b1;
      next_load_pend = 1'b1;
    end else if (stop) begin
      next_running   = 1'b0;
      next_load_pend = 1'b0;
    end else if (running && tick) begin
      if (load_pend) begin
        next_count     = period;
        next_load_pend = 1'b0;
        fire           = start_int;
      end else if (count == '0) begin
        next_count = period;
        fire       = 1'b1;
      end else begin
        next_count = count - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Counter state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count     <= '0;
      running   <= 1'b0;
      load_pend <= 1'b0;
    end else if (ce) begin
      count     <= next_count;
      running   <= next_running;
      load_pend <= next_load_pend;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_reload;
    ce && !clr && !start && !stop && running && tick && !load_pend && count == '0
      |-> fire ##1 count == $past(period);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload at zero");

  property p_decr;
    ce && !clr && !start && !stop && running && tick && !load_pend && count != '0
      |=> count == $past(count) - {{(W-1){1'b0}}, 1'b1};
  endproperty
  a_decr: assert property (p_decr) else $error("counter did not decrement");

  property p_first;
    !clr && !start && !stop && running && tick && load_pend |-> fire == start_int;
  endproperty
  a_first: assert property (p_first) else $error("wrong event on first load");

  property p_stop;
    ce && !clr && stop && !start |=> !running && $stable(count);
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not freeze");
endmodule // chan_counter

// ---- hdl/input_path.sv ----
// Timer input conditioning: synchroniser, optional filter, edge pulse
`timescale 1ns/1ps
`include "timer_cfg.svh"
module input_path (
  input  wire logic clk,        // Clock
  input  wire logic sys_rst,    // Async reset
  input  wire logic ce,         // Clock enable
  input  wire logic clr,        // Unit disabled
  input  wire logic pin,        // Raw timer input
  input  wire logic op_tick,    // Operating clock tick
  input  wire logic in_use,     // Input selected by mode
  input  wire logic filt_en,    // Filter enable
  output logic      level,      // Conditioned level
  output logic      edge_pulse  // Change pulse
);
  logic sync1, sync2, samp;
  logic next_samp, next_level, next_edge;

  // Filter and edge detection; sync1 feeds only sync2
  always_comb begin
    next_samp  = samp;
    next_level = level;
    if (clr) begin
      next_samp  = 1'b0;
      next_level = 1'b0;
    end else if (!filt_en) begin
      next_level = sync2;
    end else if (in_use && op_tick) begin
      next_samp = sync2;
      if (sync2 == samp) next_level = sync2;
    end
    next_edge = next_level != level;
  end

  // Two-stage synchroniser, then conditioned state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1      <= 1'b0;
      sync2      <= 1'b0;
      samp       <= 1'b0;
      level      <= 1'b0;
      edge_pulse <= 1'b0;
    end else if (ce) begin
      sync1      <= pin;
      sync2      <= sync1;
      samp       <= next_samp;
      level      <= next_level;
      edge_pulse <= next_edge;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_filter_hold;
    ce && !clr && filt_en && in_use && op_tick && (sync2 != samp) |=> $stable(level);
  endproperty
  a_filter_hold: assert property (p_filter_hold) else $error("filter passed unstable level");

  property p_gate;
    ce && !clr && filt_en && !in_use |=> $stable(samp);
  endproperty
  a_gate: assert property (p_gate) else $error("filter ran while input unused");

  property p_edge;
    $past(ce) && edge_pulse |-> level != $past(level);
  endproperty
  a_edge: assert property (p_edge) else $error("edge pulse without level change");
endmodule // input_path

// ---- hdl/timer_cfg.svh ----
// Register map, field positions and reset values of the timer unit
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

`define NUM_CH    4
`define A_UNIT    6'h00
`define A_PRESC   6'h01
`define A_START   6'h02
`define A_STOP    6'h03
`define A_OUT     6'h04
`define A_OUTEN   6'h05
`define A_POL     6'h06
`define A_OMODE   6'h07
`define A_FILT    6'h08
`define A_INSTAT  6'h09
`define A_CHAN    2'h1
`define S_MODE    2'h0
`define S_PER     2'h1
`define S_CNT     2'h2
`define M_CKSEL   15
`define M_CCS     12
`define M_SPLIT   11
`define M_STS_HI  9
`define M_STS_LO  8
`define M_STINT   0
`define ST_HI1    9
`define ST_HI3    11
`define PA_LSB    0
`define PB_LSB    4
`define PRE_ONE   16'h0001
`define RST_WORD  16'h0000
`define RST_NIB   4'h0
`define RST_BYTE  8'h00
`define RST_BUS   32'h0000_0000

`endif

// ---- hdl/timer_pkg.sv ----
// Types shared by the timer unit files
package timer_pkg;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ANS  = 2'b10
  } bus_state_t;
  typedef logic [31:0] bus_word_t;
  typedef logic [15:0] word16_t;
endpackage

// ---- hdl/timer_unit.sv ----
// Timer unit top: Avalon slave, prescaler, interval and square-wave channels
//
// Local design decisions: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "timer_cfg.svh"
module timer_unit (
  input  wire logic                 clk,               // 250 MHz clock
  input  wire logic                 sys_rst,           // Async reset, high
  input  wire logic                 ce,                // Clock enable
  input  wire logic [7:0]           avs_address,       // Byte address
  input  wire logic                 avs_read,          // Read request
  input  wire logic                 avs_write,         // Write request
  input  wire logic [3:0]           avs_byteenable,    // Byte lanes
  input  wire timer_pkg::bus_word_t avs_writedata,     // Write data
  output timer_pkg::bus_word_t      avs_readdata,      // Read data
  output logic                      avs_waitrequest,   // Stall
  input  wire logic [3:0]           timer_input_pin,   // Async inputs
  output logic      [3:0]           timer_output_pin,  // Channel outputs
  output logic      [3:0]           channel_interrupt, // Interval pulses
  output logic      [1:0]           upper_interrupt    // Upper halves ch1, ch3
);
  import timer_pkg::*;

  bus_state_t  state, next_state;
  logic        wait_q, next_wait;
  bus_word_t   rdata, next_rdata, rd_mux, merged, trig, be_mask;
  logic        unit_en, next_unit_en;
  logic [3:0]  presc_a, next_presc_a, presc_b, next_presc_b;
  logic [15:0] presc_cnt, next_presc_cnt, mask_a, mask_b;
  logic [3:0]  out_lvl, next_out_lvl, out_en, next_out_en;
  logic [3:0]  filt_en, next_filt_en;
  logic [7:0]  out_pol, next_out_pol, out_mode, next_out_mode;
  word16_t     mode [`NUM_CH];
  word16_t     next_mode [`NUM_CH];
  word16_t     period [`NUM_CH];
  word16_t     next_period [`NUM_CH];
  word16_t     per_lo [`NUM_CH];
  word16_t     lo_cnt [`NUM_CH];
  word16_t     count_rd [`NUM_CH];
  logic [7:0]  hi_cnt [`NUM_CH];
  logic [3:0]  next_pin, next_irq;
  logic [1:0]  next_irq_hi;
  logic        req, take, wr_en, chan_hit, wr_out, tick_a, tick_b, clr;
  logic [5:0]  widx;
  logic [1:0]  csel, csub;
  logic [3:0]  in_use, op_tick, cnt_tick, split, lvl, edge_p;
  logic [3:0]  start_lo, stop_lo, start_hi, stop_hi;
  logic [3:0]  lo_run, lo_fire, hi_run, hi_fire;

  // Address decode; the write lands at the edge where waitrequest is low
  assign req      = avs_read | avs_write;
  assign take     = req & ~wait_q;
  assign wr_en    = take & avs_write;
  assign widx     = avs_address[7:2];
  assign chan_hit = widx[5:4] == `A_CHAN;
  assign csel     = widx[3:2];
  assign csub     = widx[1:0];
  assign wr_out   = wr_en & unit_en & ~chan_hit & (widx == `A_OUT);
  assign clr      = ~unit_en;
  assign be_mask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                     {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign merged   = (rd_mux & ~be_mask) | (avs_writedata & be_mask);
  assign trig     = avs_writedata & be_mask;

  // Trigger bits are never stored, so they always read back as status
  assign start_lo = (wr_en && unit_en && !chan_hit && widx == `A_START) ? trig[3:0] : 4'h0;
  assign stop_lo  = (wr_en && unit_en && !chan_hit && widx == `A_STOP) ? trig[3:0] : 4'h0;
  assign start_hi = {trig[`ST_HI3], 1'b0, trig[`ST_HI1], 1'b0}
                    & {4{wr_en && unit_en && !chan_hit && widx == `A_START}};
  assign stop_hi  = {trig[`ST_HI3], 1'b0, trig[`ST_HI1], 1'b0}
                    & {4{wr_en && unit_en && !chan_hit && widx == `A_STOP}};

  // Two operating clocks as divide-by-power-of-two ticks
  assign mask_a = (`PRE_ONE << presc_a) - `PRE_ONE;
  assign mask_b = (`PRE_ONE << presc_b) - `PRE_ONE;
  assign tick_a = unit_en & ((presc_cnt & mask_a) == mask_a);
  assign tick_b = unit_en & ((presc_cnt & mask_b) == mask_b);

  // Channels; all four built alike, channels 1 and 3 add an 8-bit upper half
  for (genvar ch = 0; ch < `NUM_CH; ch++) begin : g_ch
    assign in_use[ch]   = mode[ch][`M_CCS] | mode[ch][`M_STS_HI] | mode[ch][`M_STS_LO];
    assign op_tick[ch]  = mode[ch][`M_CKSEL] ? tick_b : tick_a;
    assign cnt_tick[ch] = mode[ch][`M_CCS] ? edge_p[ch] : op_tick[ch];
    assign split[ch]    = (ch % 2 == 1) && mode[ch][`M_SPLIT];
    assign per_lo[ch]   = split[ch] ? {`RST_BYTE, period[ch][7:0]} : period[ch];
    assign count_rd[ch] = split[ch] ? {hi_cnt[ch], lo_cnt[ch][7:0]} : lo_cnt[ch];

    input_path u_in (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .ce         (ce),
      .clr        (clr),
      .pin        (timer_input_pin[ch]),
      .op_tick    (op_tick[ch]),
      .in_use     (in_use[ch]),
      .filt_en    (filt_en[ch]),
      .level      (lvl[ch]),
      .edge_pulse (edge_p[ch])
    );

    chan_counter #(.W(16)) u_lo (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .ce        (ce),
      .clr       (clr),
      .start     (start_lo[ch]),
      .stop      (stop_lo[ch]),
      .tick      (cnt_tick[ch]),
      .start_int (mode[ch][`M_STINT]),
      .period    (per_lo[ch]),
      .count     (lo_cnt[ch]),
      .running   (lo_run[ch]),
      .fire      (lo_fire[ch])
    );

    if (ch % 2 == 1) begin : g_hi
      // Upper half runs on its own trigger only while split
      chan_counter #(.W(8)) u_hi (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .ce        (ce),
        .clr       (clr | ~split[ch]),
        .start     (start_hi[ch]),
        .stop      (stop_hi[ch]),
        .tick      (op_tick[ch]),
        .start_int (mode[ch][`M_STINT]),
        .period    (period[ch][15:8]),
        .count     (hi_cnt[ch]),
        .running   (hi_run[ch]),
        .fire      (hi_fire[ch])
      );
    end else begin : g_nohi
      assign hi_cnt[ch]  = `RST_BYTE;
      assign hi_run[ch]  = 1'b0;
      assign hi_fire[ch] = 1'b0;
    end
  end

  // Read mux; a disabled unit reads zero except its enable bit
  always_comb begin
    rd_mux = `RST_BUS;
    if (!chan_hit && widx == `A_UNIT) begin
      rd_mux[0] = unit_en;
    end else if (unit_en && chan_hit) begin
      case (csub)
        `S_MODE: rd_mux[15:0] = mode[csel];
        `S_PER:  rd_mux[15:0] = period[csel];
        `S_CNT:  rd_mux[15:0] = count_rd[csel];
        default: rd_mux = `RST_BUS;
      endcase
    end else if (unit_en) begin
      case (widx)
        `A_PRESC:  rd_mux[7:0] = {presc_b, presc_a};
        `A_START,
        `A_STOP: begin
          rd_mux[3:0]      = lo_run;
          rd_mux[`ST_HI1] = hi_run[1];
          rd_mux[`ST_HI3] = hi_run[3];
        end
        `A_OUT:    rd_mux[3:0] = out_lvl;
        `A_OUTEN:  rd_mux[3:0] = out_en;
        `A_POL:    rd_mux[7:0] = out_pol;
        `A_OMODE:  rd_mux[7:0] = out_mode;
        `A_FILT:   rd_mux[3:0] = filt_en;
        `A_INSTAT: rd_mux[3:0] = lvl;
        default:   rd_mux = `RST_BUS;
      endcase
    end
  end

  // Bus handshake: one wait cycle, then a one-cycle answer
  always_comb begin
    next_state = state;
    next_wait  = wait_q;
    next_rdata = rdata;
    unique case (state)
      BUS_IDLE: if (req) begin
        next_state = BUS_ANS;
        next_wait  = 1'b0;
        next_rdata = avs_read ? rd_mux : `RST_BUS;
      end
      BUS_ANS: begin
        next_state = BUS_IDLE;
        next_wait  = 1'b1;
      end
    endcase
  end

  // Register file, output latches and interrupt pulses
  always_comb begin
    next_unit_en   = unit_en;
    next_presc_a   = presc_a;
    next_presc_b   = presc_b;
    next_presc_cnt = presc_cnt + `PRE_ONE;
    next_out_lvl   = out_lvl;
    next_out_en    = out_en;
    next_out_pol   = out_pol;
    next_out_mode  = out_mode;
    next_filt_en   = filt_en;
    next_mode      = mode;
    next_period    = period;
    next_irq       = lo_fire;
    next_irq_hi    = {hi_fire[3], hi_fire[1]};
    if (wr_en && !chan_hit && widx == `A_UNIT) next_unit_en = merged[0];
    if (wr_en && unit_en) begin
      if (chan_hit) begin
        if (csub == `S_MODE) next_mode[csel] = merged[15:0];
        if (csub == `S_PER) next_period[csel] = merged[15:0];
      end else begin
        case (widx)
          `A_PRESC: begin
            next_presc_a = merged[`PA_LSB +: 4];
            next_presc_b = merged[`PB_LSB +: 4];
          end
          `A_OUTEN: next_out_en   = merged[3:0];
          `A_POL:   next_out_pol  = merged[7:0];
          `A_OMODE: next_out_mode = merged[7:0];
          `A_FILT:  next_filt_en  = merged[3:0];
          default:  next_unit_en  = next_unit_en;
        endcase
      end
    end
    for (int i = 0; i < `NUM_CH; i++) begin
      if (lo_fire[i] && out_en[i]) begin
        next_out_lvl[i] = ~out_lvl[i];
      end else if (wr_out && !out_en[i]) begin
        next_out_lvl[i] = merged[i];
      end
      next_pin[i] = out_mode[i] ? (out_lvl[i] ^ out_pol[i]) : out_lvl[i];
    end
    // Disabled unit: everything but the enable bit returns to reset
    if (!unit_en) begin
      next_presc_a   = `RST_NIB;
      next_presc_b   = `RST_NIB;
      next_presc_cnt = `RST_WORD;
      next_out_lvl   = `RST_NIB;
      next_out_en    = `RST_NIB;
      next_out_pol   = `RST_BYTE;
      next_out_mode  = `RST_BYTE;
      next_filt_en   = `RST_NIB;
      next_pin       = `RST_NIB;
      for (int i = 0; i < `NUM_CH; i++) begin
        next_mode[i]   = `RST_WORD;
        next_period[i] = `RST_WORD;
      end
    end
  end

  // State registers, frozen while ce is low
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state             <= BUS_IDLE;
      wait_q            <= 1'b1;
      rdata             <= `RST_BUS;
      unit_en           <= 1'b0;
      presc_a           <= `RST_NIB;
      presc_b           <= `RST_NIB;
      presc_cnt         <= `RST_WORD;
      out_lvl           <= `RST_NIB;
      out_en            <= `RST_NIB;
      out_pol           <= `RST_BYTE;
      out_mode          <= `RST_BYTE;
      filt_en           <= `RST_NIB;
      timer_output_pin  <= `RST_NIB;
      channel_interrupt <= `RST_NIB;
      upper_interrupt   <= 2'b00;
      for (int i = 0; i < `NUM_CH; i++) begin
        mode[i]   <= `RST_WORD;
        period[i] <= `RST_WORD;
      end
    end else if (ce) begin
      state             <= next_state;
      wait_q            <= next_wait;
      rdata             <= next_rdata;
      unit_en           <= next_unit_en;
      presc_a           <= next_presc_a;
      presc_b           <= next_presc_b;
      presc_cnt         <= next_presc_cnt;
      out_lvl           <= next_out_lvl;
      out_en            <= next_out_en;
      out_pol           <= next_out_pol;
      out_mode          <= next_out_mode;
      filt_en           <= next_filt_en;
      timer_output_pin  <= next_pin;
      channel_interrupt <= next_irq;
      upper_interrupt   <= next_irq_hi;
      mode              <= next_mode;
      period            <= next_period;
    end
  end

  assign avs_readdata    = rdata;
  assign avs_waitrequest = wait_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_unit_off;
    ce && !unit_en |=> lo_run == 4'h0 && channel_interrupt == 4'h0;
  endproperty
  a_unit_off: assert property (p_unit_off) else $error("channel alive while unit off");

  property p_toggle;
    ce && lo_fire[0] && out_en[0] |=> out_lvl[0] != $past(out_lvl[0]) && channel_interrupt[0];
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle on interval event");

  property p_wr_ignored;
    ce && wr_out && out_en[1] && !lo_fire[1] |=> $stable(out_lvl[1]);
  endproperty
  a_wr_ignored: assert property (p_wr_ignored) else $error("output write not ignored");

  property p_pol_ignored;
    ce && unit_en && !out_mode[2] |=> timer_output_pin[2] == $past(out_lvl[2]);
  endproperty
  a_pol_ignored: assert property (p_pol_ignored) else $error("polarity used in master mode");

  c_toggle: cover property (lo_fire[0] && out_en[0]);
  c_upper:  cover property (hi_fire[1]);
  c_start:  cover property (take && avs_write && widx == `A_START);
endmodule // timer_unit

// ---- verif/pin_source.sv ----
// Behavioural signal source driving the timer input pins
`timescale 1ns/1ps
module pin_source (
  input  wire logic [3:0] want, // Requested levels
  output logic      [3:0] pin   // Driven timer inputs
);
  // Edges land mid-cycle, 1.3 ns after the rising bench clock edge that changes want, so the synchroniser is exercised
  initial pin = 4'h0;
  always @(want) pin <= #1.3 want;
endmodule // pin_source

// ---- verif/test_timer_channel_interval_square_wave.sv ----
// Self-checking bench for the timer unit
`timescale 1ns/1ps
`include "timer_cfg.svh"
module test_timer_channel_interval_square_wave;
  import timer_pkg::*;
  logic            clk, sys_rst, ce, rd, wr, wreq, o0, o1;
  logic      [7:0] adr;
  logic      [3:0] be, want, pin, tout, irq;
  logic      [1:0] uirq;
  logic      [5:0] ev;
  bus_word_t       wdat, rdat, v, w;
  int              n_errors, total_checks, n, p, k;
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("BAD %0t got %h exp %h", $time, a, b); end end

  timer_unit u_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_byteenable(be), .avs_writedata(wdat),
    .avs_readdata(rdat), .avs_waitrequest(wreq), .timer_input_pin(pin),
    .timer_output_pin(tout), .channel_interrupt(irq), .upper_interrupt(uirq));
  pin_source u_src (.want(want), .pin(pin));

  // Upper-half pulses sit above the four lower ones
  assign ev = {uirq, irq};

  // Clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // One Avalon access; request held until waitrequest sampled low at a rising edge
  task automatic bus(input logic [5:0] idx, input logic we, input bus_word_t d,
                     output bus_word_t q);
    @(posedge clk);
    adr <= {idx, 2'b00};
    wdat <= d;
    wr <= we;
    rd <= !we;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // Cycles until the next pulse on event bit b; a missing pulse is a mismatch
  task automatic irq_gap(input int b, output int c);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (ev[b] !== 1'b1 && c < 3000);
    if (ev[b] !== 1'b1) begin
      n_errors++;
      $display("BAD %0t no interrupt on event %0d", $time, b);
    end
  endtask

  // Interval in count clocks for a given period value
  function automatic int exp_gap(input int per);
    return per + 1;
  endfunction

  task automatic end_sim;
    $display("Errors %0d, checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog well beyond the expected run of under a thousand cycles
  initial begin
    #200000;
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    end_sim;
  end

  initial begin
    sys_rst = 1'b1; rd = 1'b0; wr = 1'b0; adr = 8'h00; wdat = `RST_BUS;
    be = 4'hF; want = 4'h0; n_errors = 0; total_checks = 0;
    ce = 1'b1;
    k = $urandom(32'hA922C3F0);
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    // Disabled unit refuses writes; enabling leaves channels stopped
    bus(6'h11, 1'b1, 32'h0000_0005, v);
    bus(`A_UNIT, 1'b1, 32'h0000_0001, v);
    bus(6'h11, 1'b0, `RST_BUS, v); `CHK(v, `RST_BUS)
    bus(`A_START, 1'b0, `RST_BUS, v); `CHK(v, `RST_BUS)
    bus(6'h3F, 1'b0, `RST_BUS, v); `CHK(v, `RST_BUS)
    // Square wave on channel 0, random period, both start-interrupt settings
    p = $urandom_range(20, 2);
    bus(6'h11, 1'b1, bus_word_t'(p), v);
    bus(`A_POL, 1'b1, 32'h0000_00FF, v);
    bus(`A_OUTEN, 1'b1, 32'h0000_0001, v);
    for (k = 1; k >= 0; k--) begin
      bus(6'h10, 1'b1, bus_word_t'(k), v);
      bus(`A_START, 1'b1, 32'h0000_0001, v);
      irq_gap(0, n);
      `CHK(n <= 3, k[0])
      o0 = tout[0];
      repeat (3) begin
        irq_gap(0, n);
        `CHK(n, exp_gap(p))
        o1 = tout[0];
        `CHK(o1, !o0)
        o0 = o1;
      end
      // Five frozen edges; counting starts after them, so the gap looks unchanged
      @(posedge clk);
      ce <= 1'b0;
      repeat (5) @(posedge clk);
      ce <= 1'b1;
      irq_gap(0, n);
      `CHK(n, exp_gap(p))
      // New period may land on a reload edge; the third gap surely uses it
      p = p + 3;
      bus(6'h11, 1'b1, bus_word_t'(p), v);
      repeat (3) irq_gap(0, n);
      `CHK(n, exp_gap(p))
      // Stop clears the run status and freezes the count
      bus(`A_STOP, 1'b1, 32'h0000_0001, v);
      bus(`A_START, 1'b0, `RST_BUS, v); `CHK(v[0], 1'b0)
      bus(6'h12, 1'b0, `RST_BUS, v);
      w = v;
      repeat (4) @(posedge clk);
      bus(6'h12, 1'b0, `RST_BUS, v); `CHK(v, w)
      // Polarity bits are all ones but output mode is zero, so the pin must still equal the latch
      bus(`A_OUT, 1'b0, `RST_BUS, v); `CHK(tout[0], v[0])
    end
    // Output latch bit of an enabled output ignores writes
    bus(`A_OUT, 1'b0, `RST_BUS, w);
    bus(`A_OUT, 1'b1, {28'h0, ~w[3:0]}, v);
    bus(`A_OUT, 1'b0, `RST_BUS, v); `CHK(v[3:0], {~w[3:1], w[0]})
    // Input path on channel 2, filter off then on, alternating levels
    for (k = 0; k < 4; k++) begin
      bus(`A_FILT, 1'b1, {29'h0, k[1], 2'h0}, v);
      bus(6'h18, 1'b1, 32'h0000_0100, v);
      repeat (4) @(posedge clk);
      bus(`A_START, 1'b1, 32'h0000_0004, v);
      // Channel 2 pin always flips so a stuck path cannot pass
      want <= {1'($urandom), ~want[2], 2'($urandom)};
      repeat (12) @(posedge clk);
      bus(`A_INSTAT, 1'b0, `RST_BUS, v); `CHK(v[2], want[2])
    end
    // Split channel 1: both 8-bit halves run as independent interval timers
    k = $urandom_range(9, 1);
    p = $urandom_range(9, 1);
    bus(6'h14, 1'b1, 32'h0000_0800, v);
    bus(6'h15, 1'b1, bus_word_t'({p[7:0], k[7:0]}), v);
    bus(`A_START, 1'b1, 32'h0000_0202, v);
    repeat (2) irq_gap(4, n);
    `CHK(n, exp_gap(p))
    repeat (2) irq_gap(1, n);
    `CHK(n, exp_gap(k))
    end_sim;
  end
endmodule // test_timer_channel_interval_square_wave
